// *** design/mcgw_map.svh ***
// Register offsets, field positions and reset values of the master clock gate block
// Behaviour
// R1: Writing one to bit 15 stops master clock.
// R2: Hardware reset low restarts stopped clock.
// R3: Enabled RTC alarm or periodic restarts clock.
// R4: Low level on either irq pin restarts.
// R5: High level on resume pin restarts clock.
// R6: Asserted pin wake forces bit 15 to zero.
// R7: Wake condition beats software write of one.
// R8: Resume pin as output never wakes clock.
// R9: Driver holds resume pin low before stop.
// R10: Clock-disable bit resets to zero.
`ifndef MCGW_MAP_SVH
`define MCGW_MAP_SVH
// Register indices; the byte address is four times the index
`define MCGW_PCGC_INDEX     16'h1c02
`define MCGW_WAKE_CTL_INDEX 16'h1c04
`define MCGW_STATUS_INDEX   16'h1c08
// Pin levels with no wake pending: irq lines high, resume low
`define MCGW_PIN_IDLE       5'h18
`define MCGW_PCGC_STOP_BIT 15
`define MCGW_PCGC_RESET    16'h0000
`define MCGW_WAKE_CTL_RESET 16'h0000
`define MCGW_CTL_RES_OUT_BIT 0
`define MCGW_CTL_RES_DO_BIT  1
`define MCGW_CTL_ALARM_EN_BIT 2
`define MCGW_CTL_PERIOD_EN_BIT 3
`endif

// *** design/mcgw_pkg.sv ***
// Types shared by the master clock gate block
package mcgw_pkg;
  typedef enum logic [1:0] {
    mcgw_resp_okay,
    mcgw_resp_exokay,
    mcgw_resp_slverr,
    mcgw_resp_decerr
  } mcgw_resp_t;

  typedef struct packed {
    logic irq_a_n;
    logic irq_b_n;
    logic resume_in;
    logic rtc_alarm;
    logic rtc_periodic;
  } mcgw_wake_src_t;
endpackage

// *** design/mcgw_master_clock_gate.sv ***
// Master clock gate with level wake-up, behind an AXI4-Lite register slave
//
// Design decision made here: the AXI4-Lite slave port.
`include "mcgw_map.svh"
module mcgw_master_clock_gate #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address and data
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  // AXI4-Lite write response
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  // Wake sources, asynchronous
  input  wire mcgw_pkg::mcgw_wake_src_t wake_src,
  // Resume pin drive
  output logic                        resume_pin_o,
  output logic                        resume_pin_oe,
  // Master clock stop request to the clock tree
  output logic                        master_clk_stop
);

  // Byte addresses reach 0x7020, so narrower buses cannot decode them
  if (ADDR_W < 15 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must be 15..32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; levels only, no edge detection anywhere
  mcgw_pkg::mcgw_wake_src_t sync1_ff;
  mcgw_pkg::mcgw_wake_src_t sync2_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Idle levels, so leaving reset never looks like a wake
      sync1_ff <= `MCGW_PIN_IDLE;
      sync2_ff <= `MCGW_PIN_IDLE;
    end else begin
      sync1_ff <= wake_src;
      sync2_ff <= sync1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] pcgc_ff;
  logic [15:0] wake_ctl_ff;
  logic        aw_hold_ff;
  logic        w_hold_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        stop_ff;
  logic        res_o_ff;
  logic        res_oe_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        arready_ff;

  wire res_is_out = wake_ctl_ff[`MCGW_CTL_RES_OUT_BIT];
  wire pin_wake   = !sync2_ff.irq_a_n || !sync2_ff.irq_b_n                // R4
                    || (sync2_ff.resume_in && !res_is_out);             // R5 R8
  wire rtc_wake   = (sync2_ff.rtc_alarm && wake_ctl_ff[`MCGW_CTL_ALARM_EN_BIT])
                    || (sync2_ff.rtc_periodic && wake_ctl_ff[`MCGW_CTL_PERIOD_EN_BIT]); // R3
  // Levels only: a stopped clock has no edges to detect with
  wire wake_any   = pin_wake || rtc_wake;

  ////////////////////////////////////////////////////////////////////////////
  // Byte addresses, four times each register index, fully decoded
  wire [ADDR_W-1:0] pcgc_addr = ADDR_W'({`MCGW_PCGC_INDEX, 2'b00});
  wire [ADDR_W-1:0] ctl_addr  = ADDR_W'({`MCGW_WAKE_CTL_INDEX, 2'b00});
  wire [ADDR_W-1:0] st_addr   = ADDR_W'({`MCGW_STATUS_INDEX, 2'b00});

  // Write path: address and data accepted in either order
  wire aw_have = aw_hold_ff || s_axi_awvalid;
  wire w_have  = w_hold_ff || s_axi_wvalid;
  wire wr_go   = aw_have && w_have && !bvalid_ff;
  wire [ADDR_W-1:0] wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
  wire [3:0]  wr_strb = w_hold_ff ? wstrb_ff : s_axi_wstrb;
  wire wr_hit_pcgc = wr_addr == pcgc_addr;
  wire wr_hit_ctl  = wr_addr == ctl_addr;
  wire wr_hit_st   = wr_addr == st_addr;
  wire wr_hit_any  = wr_hit_pcgc || wr_hit_ctl || wr_hit_st;
  wire [15:0] wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  wire [15:0] pcgc_wr = wr_go && wr_hit_pcgc ?
                        (pcgc_ff & ~wmask) | (wr_data[15:0] & wmask) : pcgc_ff;
  // Clear beats set, so a pending wake defeats a stop write
  wire [15:0] nxt_pcgc_ff = wake_any ?
                        pcgc_wr & ~(16'h0001 << `MCGW_PCGC_STOP_BIT) : pcgc_wr; // R6 R7 R2
  wire [15:0] nxt_wake_ctl_ff = wr_go && wr_hit_ctl ?
                        (wake_ctl_ff & ~wmask) | (wr_data[15:0] & wmask) : wake_ctl_ff;

  // A slot stays held until the other half arrives and no write response is pending
  wire nxt_aw_hold_ff = aw_have && !wr_go;
  wire nxt_w_hold_ff  = w_have && !wr_go;
  wire nxt_bvalid_ff  = wr_go || (bvalid_ff && !s_axi_bready);

  // Address slot; ready is a flop so the port sees no gate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      awready_ff <= 1'b1;
      awaddr_ff  <= '0;
    end else begin
      aw_hold_ff <= nxt_aw_hold_ff;
      awready_ff <= !nxt_aw_hold_ff;
      if (s_axi_awvalid && !aw_hold_ff) begin
        awaddr_ff <= s_axi_awaddr;
      end
    end
  end

  // Data slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff <= 1'b0;
      wready_ff <= 1'b1;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else begin
      w_hold_ff <= nxt_w_hold_ff;
      wready_ff <= !nxt_w_hold_ff;
      if (s_axi_wvalid && !w_hold_ff) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // Response; one write in flight, the next waits for bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'h0;
    end else begin
      bvalid_ff <= nxt_bvalid_ff;
      if (wr_go) begin
        bresp_ff <= wr_hit_any ? mcgw_pkg::mcgw_resp_okay : mcgw_pkg::mcgw_resp_decerr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate state; reset also restarts the clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcgc_ff     <= `MCGW_PCGC_RESET;                                  // R10 R2
      wake_ctl_ff <= `MCGW_WAKE_CTL_RESET;
      stop_ff     <= 1'b0;
      res_o_ff    <= 1'b0;
      res_oe_ff   <= 1'b0;
    end else begin
      pcgc_ff     <= nxt_pcgc_ff;
      wake_ctl_ff <= nxt_wake_ctl_ff;
      stop_ff     <= nxt_pcgc_ff[`MCGW_PCGC_STOP_BIT];                  // R1
      res_o_ff    <= nxt_wake_ctl_ff[`MCGW_CTL_RES_DO_BIT];
      res_oe_ff   <= nxt_wake_ctl_ff[`MCGW_CTL_RES_OUT_BIT];            // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  wire rd_hit_pcgc = s_axi_araddr == pcgc_addr;
  wire rd_hit_ctl  = s_axi_araddr == ctl_addr;
  wire rd_hit_st   = s_axi_araddr == st_addr;
  wire rd_hit_any  = rd_hit_pcgc || rd_hit_ctl || rd_hit_st;
  // Status shows the synced pins, so software sees what the gate sees
  wire [31:0] status_word = {25'h0000000, stop_ff, wake_any, sync2_ff};
  wire [31:0] rd_word = rd_hit_pcgc ? {16'h0000, pcgc_ff} :
                        rd_hit_ctl  ? {16'h0000, wake_ctl_ff} :
                        rd_hit_st   ? status_word : 32'h0000_0000;
  wire rd_go         = s_axi_arvalid && !rvalid_ff;
  wire nxt_rvalid_ff = rd_go || (rvalid_ff && !s_axi_rready);

  // Read answer; arready is the free slot, one flop deep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= 2'h0;
    end else begin
      rvalid_ff  <= nxt_rvalid_ff;
      arready_ff <= !nxt_rvalid_ff;
      if (rd_go) begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_hit_any ? mcgw_pkg::mcgw_resp_okay : mcgw_pkg::mcgw_resp_decerr;
      end
    end
  end

  // Every port straight from a flop
  assign s_axi_awready   = awready_ff;
  assign s_axi_wready    = wready_ff;
  assign s_axi_bvalid    = bvalid_ff;
  assign s_axi_bresp     = bresp_ff;
  assign s_axi_arready   = arready_ff;
  assign s_axi_rvalid    = rvalid_ff;
  assign s_axi_rdata     = rdata_ff;
  assign s_axi_rresp     = rresp_ff;
  assign master_clk_stop = stop_ff;
  assign resume_pin_o    = res_o_ff;
  assign resume_pin_oe   = res_oe_ff;
endmodule

// *** verification/mcgw_wake_model.sv ***
// Far-side pins: interrupt lines, resume pin and RTC events
module mcgw_wake_model (
  // Clock and one assertion request per struct field
  input wire logic       aclk,
  input wire logic [4:0] req,
  // Pin levels
  output mcgw_pkg::mcgw_wake_src_t pins
);
  // Irq lines idle high; resume held low so that a stop can take effect
  localparam logic [4:0] IDLE = 5'h18;
  initial pins = IDLE;
  always @(posedge aclk) pins <= IDLE ^ req;
endmodule

// *** verification/mcgw_checker.sv ***
// Port checks of the master clock gate
module mcgw_checker (
  // Clock, reset and bus
  input wire logic aclk, aresetn, s_axi_bvalid, s_axi_bready, s_axi_rvalid,
  input wire logic s_axi_rready, s_axi_arready, s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  // Pins
  input wire mcgw_pkg::mcgw_wake_src_t wake_src,
  input wire logic resume_pin_oe, master_clk_stop
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire stp = master_clk_stop;
  ////////////////////////////////////////////////////////////////
  a_irq_a_wake: assert property (!wake_src.irq_a_n [*3] |=> !stp)
    else $error("stop held under irq a");
  a_irq_b_wake: assert property (!wake_src.irq_b_n [*3] |=> !stp)
    else $error("stop held under irq b");
  a_resume_wake: assert property ((wake_src.resume_in && !resume_pin_oe) [*3] |=> !stp)
    else $error("stop held under resume");
  a_stop_by_write: assert property ($rose(stp) |-> $rose(s_axi_bvalid))
    else $error("stop rose without write");
  a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> !stp && s_axi_awready)
    else $error("reset left stop set");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while rvalid");
  cover property ($rose(stp));
  cover property ($fell(stp));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule
bind mcgw_master_clock_gate mcgw_checker i_chk (.*);

// *** verification/mcgw_master_clock_gate_tb.sv ***
// Self-checking bench of the master clock gate
`include "mcgw_map.svh"
module mcgw_master_clock_gate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, resume_pin_o, resume_pin_oe, master_clk_stop;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, seed = 32'hd8b3d4a8;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, qb[$];
  logic [4:0] req = '0;
  logic [33:0] qr[$];
  mcgw_pkg::mcgw_wake_src_t wake_src;
  int bad_count = 0, n_checks = 0, cyc = 0;
  // Byte addresses are four times the register index
  localparam logic [15:0] PCGC = 16'({`MCGW_PCGC_INDEX, 2'b00});
  localparam logic [15:0] CTL = 16'({`MCGW_WAKE_CTL_INDEX, 2'b00});
  localparam logic [15:0] STS = 16'({`MCGW_STATUS_INDEX, 2'b00});
  localparam logic [3:0] CTLS [8] = '{4'hc, 4'hc, 4'hc, 4'hc, 4'hc, 4'h8, 4'h4, 4'h3};
  localparam int SRC [8] = '{4, 3, 2, 1, 0, 1, 0, 2};
  localparam bit EX [8] = '{0, 0, 0, 0, 0, 1, 1, 1};
  mcgw_master_clock_gate i_dut (.*);
  mcgw_wake_model i_far (.aclk, .req, .pins(wake_src));
  always #12.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(string n, logic [33:0] e, logic [33:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(logic [15:0] a, logic [31:0] v, logic [1:0] r);
    bit pa = 1, pw = 1;
    qb.push_back(r);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_awaddr, s_axi_wdata} <= {2'b11, a, v};
    while (pa | pw) begin
      @(posedge aclk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      {s_axi_awvalid, s_axi_wvalid} <= {pa, pw};
    end
    repeat (rnd() % 3) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [33:0] e);
    qr.push_back(e);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (rnd() % 3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", 34'(qb.pop_front()), 34'(s_axi_bresp));
    if (s_axi_rvalid && s_axi_rready) cmp("rdata", qr.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(PCGC, '0);
    rd(STS, 34'(`MCGW_PIN_IDLE));
    rd(16'h1c10, {2'h3, 32'h0});
    rd(PCGC + 16'h2, {2'h3, 32'h0});
    wr(16'h1c10, rnd(), 2'h3);
    for (int i = 0; i < 8; i++) begin
      wr(CTL, 32'(CTLS[i]), 2'h0);
      cmp("pin", 34'({resume_pin_oe, resume_pin_o}), 34'({CTLS[i][0], CTLS[i][1]}));
      rd(CTL, 34'(CTLS[i]));
      d = {16'h0, 1'b1, 15'(rnd())};
      wr(PCGC, d, 2'h0);
      cmp("stop", 34'(master_clk_stop), 34'h1);
      req <= 5'h1 << SRC[i];
      repeat (6) @(posedge aclk);
      wr(PCGC, d, 2'h0);
      cmp("stop", 34'(master_clk_stop), 34'(EX[i]));
      rd(PCGC, EX[i] ? d : d & 32'h7fff);
      rd(STS, 34'({EX[i], !EX[i], 5'(`MCGW_PIN_IDLE ^ (5'h1 << SRC[i]))}));
      req <= '0;
      wr(PCGC, '0, 2'h0);
    end
    wr(PCGC, 32'h8000, 2'h0);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    cmp("stop", 34'(master_clk_stop), 34'h0);
    aresetn <= 1'b1;
    rd(PCGC, '0);
    test_done();
  end
endmodule
